/* bsp_pkg.sv */
// Shared constants and types for the battery switchover power control block
package bsp_pkg;

  // Special function register addresses
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'hc5;
  localparam logic [7:0] ADDR_SCRATCH_THREE = 8'hfd;
  localparam logic [7:0] ADDR_SCRATCH_FOUR  = 8'hfe;
  localparam logic [7:0] ADDR_WRITE_KEY     = 8'hc1;
  localparam logic [7:0] ADDR_SWITCH_CFG    = 8'hf5;
  localparam logic [7:0] ADDR_PERIPHERAL_CONFIG_REGISTER_CFG    = 8'hf4;
  localparam logic [7:0] ADDR_INT_PIN_CFG   = 8'hff;
  localparam logic [7:0] ADDR_IE_PRIO_TWO   = 8'ha9;
  localparam logic [7:0] ADDR_EVENT_ENABLE  = 8'hec;
  localparam logic [7:0] ADDR_EVENT_FLAG    = 8'hf8;

  localparam logic [7:0] WRITE_KEY_VALUE    = 8'ha7;

  // Power control layout
  localparam int         PC_SHUTDOWN_BIT    = 4;
  localparam int         PC_DIV_W           = 3;
  localparam logic [2:0] PC_DIV_RESET       = 3'h2;

  // Switchover select field, bits 1:0
  localparam int         SEL_DISABLE_BIT    = 1;
  localparam logic [1:0] SEL_RESET          = 2'h0;
  localparam logic [1:0] SEL_MAIN_OR_DCIN   = 2'h1;

  localparam int         PERIPHERAL_CONFIG_REGISTER_SOURCE_BIT  = 6;
  localparam int         PERIPHERAL_CONFIG_REGISTER_VDD_OK_BIT  = 5;

  // External interrupt 1 field, bits 4:2
  localparam int         INT1_LSB           = 2;
  localparam logic [2:0] INT1_BATTERY_CONTROL_PIN_MASK    = 3'h3;
  localparam logic [2:0] INT1_BATTERY_CONTROL_PIN_VALUE   = 3'h1;

  localparam int         IE2_SUPPLY_IRQ_BIT = 1;

  // Event flag positions, matching the event enable layout
  localparam int         EVT_SUPERVISORY_INPUT          = 0;
  localparam int         EVT_SWITCH         = 1;
  localparam int         EVT_RESTORE        = 7;

  // Recovery qualification time
  localparam int         CLK_PERIOD_NS      = 10;
  localparam int         RECOVER_TIME_US    = 100;
  localparam int         RECOVER_CYCLES     = RECOVER_TIME_US * 1000 / CLK_PERIOD_NS;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bsp_sfr_req_t;

  typedef struct packed {
    logic vdd_low;
    logic dcin_low;
    logic battery_control_pin;
  } bsp_supply_t;

  typedef enum logic [0:0] {
    BSP_ON_MAIN    = 1'b0,
    BSP_ON_BATTERY = 1'b1
  } bsp_src_t;

endpackage

/* bsp_power_ctl.sv */
// Supply source switchover, key-protected power control and supply event flags
// What this block does
// - Two scratch bytes reset to zero, read/write, kept across power saving modes.
// - Power control bit 4 shuts the core down, only in battery mode.
// - Divider bits 2:0 give core clock 4.096 MHz over 2^n, reset 010.
// - Power control write accepted only right after key 0xA7 write.
// - Switchover on after reset; select bit 1 disables it, main always.
// - Peripheral config bit 6 reads one on main, zero on battery.
// - Switching never stalls code; metering converters off on battery.
// - Low supervisory input switches to battery when enabled; off by default.
// - Low main supply switches to battery while select bit 1 clear.
// - Interrupt field 0bx01 lets a battery pin rising edge force battery.
// - Return to main only when every enabled trigger is false.
// - Each enabled supervised level must stay good for qualifying time.
// - With pin enabled, return needs pin low plus level recovery.
// - Supply monitor interrupt off after reset; enabled by its enable bit.
// - Event enable register selects which events raise the shared interrupt.
// - Event flags latch until software writes zero to them in the flag register.
// - Select 00 main only, 01 main or supervisory, 1x disabled.
`timescale 1ns/1ps
`default_nettype none
module bsp_power_ctl #(
  parameter int RECOVER_CYCLES = bsp_pkg::RECOVER_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  input  wire bsp_pkg::bsp_sfr_req_t sfr_req_i,
  output logic [7:0]                 sfr_rdata_o,
  input  wire bsp_pkg::bsp_supply_t  supply_i,
  output logic                       battery_select_o,
  output logic [2:0]                 core_clock_div_o,
  output logic                       core_shutdown_o,
  output logic                       metering_enable_o,
  output logic                       supply_irq_o
);

  initial begin
    if (RECOVER_CYCLES < 1) $error("bsp_power_ctl: RECOVER_CYCLES must be at least 1");
  end

  logic [7:0]          scratch_three_r;
  logic [7:0]          scratch_four_r;
  logic [2:0]          div_r;
  logic                core_off_r;
  logic                key_armed_r;
  logic [1:0]          sel_r;
  logic [2:0]          int1_r;
  logic [7:0]          ie2_r;
  logic [7:0]          evt_en_r;
  logic [7:0]          flags_r;
  logic [7:0]          flags_nxt;
  logic [7:0]          evt;
  logic [7:0]          rd_mux;
  bsp_pkg::bsp_src_t   src_r;
  bsp_pkg::bsp_src_t   src_nxt;
  bsp_pkg::bsp_supply_t sup_s;
  logic                battery_control_pin_d_r;
  logic                vdd_good_q;
  logic                dcin_good_q;
  logic                wr;
  logic                pc_wr_ok;
  logic                disabled;
  logic                dcin_en;
  logic                battery_control_pin_en;
  logic                battery_control_pin_rise;
  logic                go_batt;
  logic                may_return;
  logic                on_batt;

  assign wr       = sfr_req_i.wr;
  assign on_batt  = (src_r == bsp_pkg::BSP_ON_BATTERY);
  assign pc_wr_ok = wr && key_armed_r && (sfr_req_i.addr == bsp_pkg::ADDR_POWER_CONTROL);

  // Comparator outputs and the pin are asynchronous to the core clock
  bsp_sync #(
    .W ($bits(bsp_pkg::bsp_supply_t))
  ) u_sync (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .async_i (supply_i),
    .sync_o  (sup_s)
  );

  bsp_qual #(
    .CYCLES (RECOVER_CYCLES)
  ) u_vdd_qual (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .ok_i        (!sup_s.vdd_low),
    .qualified_o (vdd_good_q)
  );

  bsp_qual #(
    .CYCLES (RECOVER_CYCLES)
  ) u_dcin_qual (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .ok_i        (!sup_s.dcin_low),
    .qualified_o (dcin_good_q)
  );

  // Scratch bytes have no power-mode reset of their own
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      scratch_three_r <= '0;
      scratch_four_r  <= '0;
    end else if (wr) begin
      if (sfr_req_i.addr == bsp_pkg::ADDR_SCRATCH_THREE) scratch_three_r <= sfr_req_i.wdata;
      if (sfr_req_i.addr == bsp_pkg::ADDR_SCRATCH_FOUR) scratch_four_r <= sfr_req_i.wdata;
    end
  end

  // Key is armed by one write and spent by the next, whatever it targets
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      key_armed_r <= 1'b0;
    end else if (wr) begin
      key_armed_r <= (sfr_req_i.addr == bsp_pkg::ADDR_WRITE_KEY) &&
                     (sfr_req_i.wdata == bsp_pkg::WRITE_KEY_VALUE);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      div_r <= bsp_pkg::PC_DIV_RESET;
    end else if (pc_wr_ok) begin
      div_r <= sfr_req_i.wdata[bsp_pkg::PC_DIV_W-1:0];
    end
  end

  // Shutdown only holds while on battery; return to main wakes the core
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      core_off_r <= 1'b0;
    end else if (!on_batt) begin
      core_off_r <= 1'b0;
    end else if (pc_wr_ok) begin
      core_off_r <= sfr_req_i.wdata[bsp_pkg::PC_SHUTDOWN_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sel_r    <= bsp_pkg::SEL_RESET;
      int1_r   <= '0;
      ie2_r    <= '0;
      evt_en_r <= '0;
    end else if (wr) begin
      if (sfr_req_i.addr == bsp_pkg::ADDR_SWITCH_CFG) sel_r <= sfr_req_i.wdata[$bits(sel_r)-1:0];
      if (sfr_req_i.addr == bsp_pkg::ADDR_INT_PIN_CFG)
        int1_r <= sfr_req_i.wdata[bsp_pkg::INT1_LSB +: $bits(int1_r)];
      if (sfr_req_i.addr == bsp_pkg::ADDR_IE_PRIO_TWO) ie2_r <= sfr_req_i.wdata;
      if (sfr_req_i.addr == bsp_pkg::ADDR_EVENT_ENABLE) evt_en_r <= sfr_req_i.wdata;
    end
  end

  // Trigger decode
  assign disabled   = sel_r[bsp_pkg::SEL_DISABLE_BIT];
  assign dcin_en    = (sel_r == bsp_pkg::SEL_MAIN_OR_DCIN);
  assign battery_control_pin_en   = ((int1_r & bsp_pkg::INT1_BATTERY_CONTROL_PIN_MASK) == bsp_pkg::INT1_BATTERY_CONTROL_PIN_VALUE);
  assign battery_control_pin_rise = sup_s.battery_control_pin && !battery_control_pin_d_r;

  assign go_batt = !disabled &&
                   (sup_s.vdd_low ||
                    (dcin_en && sup_s.dcin_low) ||
                    (battery_control_pin_en && battery_control_pin_rise));

  assign may_return = vdd_good_q &&
                      (!dcin_en || dcin_good_q) &&
                      (!battery_control_pin_en || !sup_s.battery_control_pin);

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      battery_control_pin_d_r <= 1'b0;
    end else begin
      battery_control_pin_d_r <= sup_s.battery_control_pin;
    end
  end

  always_comb begin
    src_nxt = src_r;
    unique case (src_r)
      bsp_pkg::BSP_ON_MAIN: begin
        if (go_batt) src_nxt = bsp_pkg::BSP_ON_BATTERY;
      end
      bsp_pkg::BSP_ON_BATTERY: begin
        if (disabled || may_return) src_nxt = bsp_pkg::BSP_ON_MAIN;
      end
    endcase
  end

  // Registered select so the supply switch sees one clean edge per change
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      src_r <= bsp_pkg::BSP_ON_MAIN;
    end else begin
      src_r <= src_nxt;
    end
  end

  // Events; a set in the same cycle as a clear wins
  always_comb begin
    evt                       = '0;
    evt[bsp_pkg::EVT_SUPERVISORY_INPUT]   = sup_s.dcin_low;
    evt[bsp_pkg::EVT_SWITCH]  = !on_batt && (src_nxt == bsp_pkg::BSP_ON_BATTERY);
    evt[bsp_pkg::EVT_RESTORE] = on_batt && (src_nxt == bsp_pkg::BSP_ON_MAIN);
    flags_nxt                 = flags_r;
    if (wr && (sfr_req_i.addr == bsp_pkg::ADDR_EVENT_FLAG)) flags_nxt = flags_r & sfr_req_i.wdata;
    flags_nxt = flags_nxt | evt;
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      supply_irq_o <= 1'b0;
    end else begin
      supply_irq_o <= ie2_r[bsp_pkg::IE2_SUPPLY_IRQ_BIT] && |(flags_r & evt_en_r);
    end
  end

  always_comb begin
    rd_mux = '0;
    unique case (sfr_req_i.addr)
      bsp_pkg::ADDR_SCRATCH_THREE: rd_mux = scratch_three_r;
      bsp_pkg::ADDR_SCRATCH_FOUR:  rd_mux = scratch_four_r;
      bsp_pkg::ADDR_POWER_CONTROL: begin
        rd_mux[bsp_pkg::PC_DIV_W-1:0]    = div_r;
        rd_mux[bsp_pkg::PC_SHUTDOWN_BIT] = core_off_r;
      end
      bsp_pkg::ADDR_SWITCH_CFG:    rd_mux[$bits(sel_r)-1:0] = sel_r;
      bsp_pkg::ADDR_PERIPHERAL_CONFIG_REGISTER_CFG: begin
        rd_mux[bsp_pkg::PERIPHERAL_CONFIG_REGISTER_SOURCE_BIT] = !on_batt;
        rd_mux[bsp_pkg::PERIPHERAL_CONFIG_REGISTER_VDD_OK_BIT] = !sup_s.vdd_low;
      end
      bsp_pkg::ADDR_INT_PIN_CFG:   rd_mux[bsp_pkg::INT1_LSB +: $bits(int1_r)] = int1_r;
      bsp_pkg::ADDR_IE_PRIO_TWO:   rd_mux = ie2_r;
      bsp_pkg::ADDR_EVENT_ENABLE:  rd_mux = evt_en_r;
      bsp_pkg::ADDR_EVENT_FLAG:    rd_mux = flags_r;
      default:                     rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sfr_rdata_o <= '0;
    end else begin
      sfr_rdata_o <= rd_mux;
    end
  end

  // Select changes never gate the core clock, so execution carries on
  assign battery_select_o  = on_batt;
  assign metering_enable_o = !on_batt;
  assign core_clock_div_o  = div_r;
  assign core_shutdown_o   = core_off_r && on_batt;

  chk_key_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr && !key_armed_r && sfr_req_i.addr == bsp_pkg::ADDR_POWER_CONTROL) |=> $stable(core_clock_div_o))
    else $error("power control changed without key");

  chk_key_accept: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr && key_armed_r && sfr_req_i.addr == bsp_pkg::ADDR_POWER_CONTROL)
      |=> core_clock_div_o == $past(sfr_req_i.wdata[bsp_pkg::PC_DIV_W-1:0]))
    else $error("keyed divider write not taken");

  chk_key_spent: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr && sfr_req_i.addr != bsp_pkg::ADDR_WRITE_KEY) |=> !key_armed_r)
    else $error("key survived another write");

  chk_scratch_keep: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr && sfr_req_i.addr == bsp_pkg::ADDR_SCRATCH_THREE) ##1
      (!wr || sfr_req_i.addr != bsp_pkg::ADDR_SCRATCH_THREE)[*2]
      |-> scratch_three_r == $past(sfr_req_i.wdata, 2))
    else $error("scratch byte lost");

  chk_shutdown_main: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !battery_select_o |-> !core_shutdown_o)
    else $error("core shut down on main supply");

  chk_disable_main: assert property (@(posedge clk_i) disable iff (!nrst_i)
    disabled |=> !battery_select_o)
    else $error("battery used while switchover disabled");

  chk_vdd_switch: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!disabled && sup_s.vdd_low) |=> battery_select_o && !metering_enable_o)
    else $error("low main supply did not switch");

  chk_battery_control_pin_switch: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!disabled && battery_control_pin_en && $rose(sup_s.battery_control_pin)) |=> battery_select_o)
    else $error("battery pin edge ignored");

  chk_return_qual: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (battery_select_o ##1 !battery_select_o) |-> ($past(disabled) || $past(vdd_good_q)))
    else $error("returned to main before recovery");

  chk_source_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (sfr_req_i.addr == bsp_pkg::ADDR_PERIPHERAL_CONFIG_REGISTER_CFG)
      |=> sfr_rdata_o[bsp_pkg::PERIPHERAL_CONFIG_REGISTER_SOURCE_BIT] == !$past(battery_select_o))
    else $error("source bit wrong");

  chk_switch_flag: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(battery_select_o) |-> flags_r[bsp_pkg::EVT_SWITCH])
    else $error("switch flag not latched");

  chk_irq_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !$past(ie2_r[bsp_pkg::IE2_SUPPLY_IRQ_BIT]) |-> !supply_irq_o)
    else $error("interrupt raised while disabled");

  chk_dcin_switch: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (dcin_en && sup_s.dcin_low) |=> battery_select_o)
    else $error("low supervisory input did not switch");

  chk_pin_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (battery_select_o && !disabled && battery_control_pin_en && sup_s.battery_control_pin) |=> battery_select_o)
    else $error("returned to main while battery pin high");

  chk_vdd_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (battery_select_o && !disabled && !vdd_good_q) |=> battery_select_o)
    else $error("returned to main before main supply qualified");

  chk_no_spurious: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!battery_select_o && !go_batt) |=> !battery_select_o)
    else $error("switched to battery with no trigger");

  chk_switch_keep: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (flags_r[bsp_pkg::EVT_SWITCH] && !(wr && sfr_req_i.addr == bsp_pkg::ADDR_EVENT_FLAG))
      |=> flags_r[bsp_pkg::EVT_SWITCH])
    else $error("switch flag lost without clear");

  chk_restore_flag: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $fell(battery_select_o) |-> flags_r[bsp_pkg::EVT_RESTORE])
    else $error("restore flag not latched");

endmodule
`default_nettype wire

/* bsp_power_ctl_test.sv */
// Self-checking bench for the battery switchover power control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module bsp_power_ctl_test;
  // Short recovery count keeps the run brief; the recovery ticks below are derived from it, the 12-cycle return limits are fixed
  localparam int RC = 8;
  localparam logic [7:0] KEY = bsp_pkg::ADDR_WRITE_KEY;
  localparam logic [7:0] PCR = bsp_pkg::ADDR_POWER_CONTROL;
  logic                  clk_i;
  logic                  nrst_i;
  bsp_pkg::bsp_sfr_req_t sfr_req;
  bsp_pkg::bsp_supply_t  supply;
  logic [7:0]            rdata;
  logic [2:0]            div;
  logic                  bat_sel, shut, met_en, irq;
  logic                  vdd_low, dcin_low, battery_control_pin;
  int                    errors, cmp_count;

  bsp_power_ctl #(.RECOVER_CYCLES(RC)) i_bsp_power_ctl (
    .clk_i(clk_i), .nrst_i(nrst_i), .sfr_req_i(sfr_req), .sfr_rdata_o(rdata), .supply_i(supply),
    .battery_select_o(bat_sel), .core_clock_div_o(div), .core_shutdown_o(shut),
    .metering_enable_o(met_en), .supply_irq_o(irq));
  bsp_supply_model i_bsp_supply_model (
    .vdd_low_cmd_i(vdd_low), .dcin_low_cmd_i(dcin_low), .battery_control_pin_cmd_i(battery_control_pin), .supply_o(supply));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Strobe drops for a cycle after each write so no signal is assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_req = {1'b1, a, d};
    tick(1);
    sfr_req.wr = 1'b0;
    tick(1);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    sfr_req.addr = a;
    tick(1);
    `CHK(nm, e, rdata)
  endtask
  task automatic wait_sel(input logic v, input int lim);
    int n;
    n = 0;
    while (bat_sel !== v && n < lim) begin
      tick(1);
      n++;
    end
    `CHK("battery_select", v, bat_sel)
    `CHK("metering_enable", ~v, met_en)
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic t_reset();
    `CHK("div", 3'h2, div)
    `CHK("shutdown", 1'b0, shut)
    `CHK("irq", 1'b0, irq)
    wait_sel(1'b0, 0);
    rd_chk("scratch_pad_three", 8'hfd, 8'h00);
    rd_chk("scratch_pad_four", 8'hfe, 8'h00);
    rd_chk("power_control", PCR, 8'h02);
    rd_chk("peripheral_config_register", 8'hf4, 8'h60);
    $display("test reset done");
  endtask
  task automatic t_scratch();
    wr(8'hfd, 8'ha5);
    wr(8'hfe, 8'h5a);
    wr(8'h80, 8'hff);
    rd_chk("scratch_pad_three", 8'hfd, 8'ha5);
    rd_chk("scratch_pad_four", 8'hfe, 8'h5a);
    rd_chk("unmapped", 8'h80, 8'h00);
    $display("test scratch done");
  endtask
  task automatic t_key();
    wr(PCR, 8'h05);
    `CHK("div", 3'h2, div)
    wr(KEY, 8'ha6);
    wr(PCR, 8'h05);
    `CHK("div", 3'h2, div)
    wr(KEY, 8'ha7);
    wr(8'hfd, 8'h11);
    wr(PCR, 8'h05);
    `CHK("div", 3'h2, div)
    for (int i = 7; i >= 0; i--) begin
      wr(KEY, 8'ha7);
      tick(2);
      wr(PCR, 8'(i));
      `CHK("div", 3'(i), div)
    end
    wr(KEY, 8'ha7);
    wr(PCR, 8'h12);
    `CHK("shutdown", 1'b0, shut)
    `CHK("div", 3'h2, div)
    $display("test key done");
  endtask
  task automatic t_vdd();
    wr(8'hec, 8'h82);
    wr(8'ha9, 8'h02);
    vdd_low = 1'b1;
    tick(1);
    `CHK("battery_select", 1'b0, bat_sel)
    wait_sel(1'b1, 4);
    rd_chk("peripheral_config_register", 8'hf4, 8'h00);
    rd_chk("flags", 8'hf8, 8'h02);
    rd_chk("scratch_pad_three", 8'hfd, 8'h11);
    `CHK("irq", 1'b1, irq)
    wr(8'ha9, 8'h00);
    tick(1);
    `CHK("irq", 1'b0, irq)
    wr(8'ha9, 8'h02);
    wr(8'hf8, 8'h00);
    tick(1);
    `CHK("irq", 1'b0, irq)
    wr(KEY, 8'ha7);
    wr(PCR, 8'h12);
    `CHK("shutdown", 1'b1, shut)
    vdd_low = 1'b0;
    tick(RC - 2);
    `CHK("battery_select", 1'b1, bat_sel)
    wait_sel(1'b0, 12);
    `CHK("shutdown", 1'b0, shut)
    rd_chk("flags", 8'hf8, 8'h80);
    `CHK("irq", 1'b1, irq)
    wr(8'hf8, 8'h00);
    $display("test vdd done");
  endtask
  task automatic t_dcin();
    dcin_low = 1'b1;
    tick(6);
    `CHK("battery_select", 1'b0, bat_sel)
    rd_chk("flags", 8'hf8, 8'h01);
    `CHK("irq", 1'b0, irq)
    wr(8'hf5, 8'h01);
    wait_sel(1'b1, 6);
    dcin_low = 1'b0;
    tick(RC - 2);
    `CHK("battery_select", 1'b1, bat_sel)
    wait_sel(1'b0, 12);
    vdd_low = 1'b1;
    dcin_low = 1'b1;
    wait_sel(1'b1, 6);
    dcin_low = 1'b0;
    tick(RC + 8);
    `CHK("battery_select", 1'b1, bat_sel)
    vdd_low = 1'b0;
    wait_sel(1'b0, RC + 6);
    wr(8'hf8, 8'h00);
    $display("test dcin done");
  endtask
  task automatic t_disable();
    for (int v = 2; v <= 3; v++) begin
      wr(8'hf5, 8'(v));
      vdd_low = 1'b1;
      dcin_low = 1'b1;
      tick(6);
      `CHK("battery_select", 1'b0, bat_sel)
      vdd_low = 1'b0;
      dcin_low = 1'b0;
      tick(1);
    end
    wr(8'hf5, 8'h00);
    vdd_low = 1'b1;
    wait_sel(1'b1, 6);
    wr(8'hf5, 8'h02);
    wait_sel(1'b0, 2);
    vdd_low = 1'b0;
    wr(8'hf5, 8'h00);
    tick(RC + 4);
    wr(8'hf8, 8'h00);
    $display("test disable done");
  endtask
  task automatic t_battery_control_pin();
    wr(8'hff, 8'h00);
    battery_control_pin = 1'b1;
    tick(6);
    `CHK("battery_select", 1'b0, bat_sel)
    battery_control_pin = 1'b0;
    tick(2);
    // Both encodings of the don't-care top bit must enable the pin
    for (int k = 0; k < 2; k++) begin
      wr(8'hff, (k == 0) ? 8'h04 : 8'h14);
      battery_control_pin = 1'b1;
      wait_sel(1'b1, 6);
      tick(RC + 8);
      `CHK("battery_select", 1'b1, bat_sel)
      battery_control_pin = 1'b0;
      wait_sel(1'b0, 6);
    end
    $display("test battery_control_pin done");
  endtask

  initial begin
    errors = 0;
    cmp_count = 0;
    nrst_i = 1'b0;
    sfr_req = '0;
    vdd_low = 1'b0;
    dcin_low = 1'b0;
    battery_control_pin = 1'b0;
    tick(12);
    nrst_i = 1'b1;
    tick(1);
    t_reset();
    t_scratch();
    t_key();
    t_vdd();
    t_dcin();
    t_disable();
    t_battery_control_pin();
    tally_and_finish();
  end
  // Whole sequence needs well under two thousand cycles
  initial begin
    #300000;
    errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* bsp_qual.sv */
// Level qualifier: output rises once the input has held high for CYCLES clocks
`timescale 1ns/1ps
`default_nettype none
module bsp_qual #(
  parameter int CYCLES = 10000
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic ok_i,
  output logic      qualified_o
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES);

  logic [CW-1:0] cnt_r;

  initial begin
    if (CYCLES < 1) $error("bsp_qual: CYCLES must be at least 1");
  end

  // Any dip restarts the wait, so a bouncing level never qualifies
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_r <= '0;
    end else if (!ok_i) begin
      cnt_r <= '0;
    end else if (cnt_r != LAST) begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  assign qualified_o = ok_i && (cnt_r == LAST);

endmodule
`default_nettype wire

/* bsp_supply_model.sv */
// Behavioural model of the supply comparators and the battery control pin
`timescale 1ns/1ps
`default_nettype none
module bsp_supply_model (
  input  wire logic                 vdd_low_cmd_i,
  input  wire logic                 dcin_low_cmd_i,
  input  wire logic                 battery_control_pin_cmd_i,
  output wire bsp_pkg::bsp_supply_t supply_o
);
  // Comparators settle a little after the level moves, never on the clock edge itself
  assign #2 supply_o = {vdd_low_cmd_i, dcin_low_cmd_i, battery_control_pin_cmd_i};
endmodule
`default_nettype wire

/* bsp_sync.sv */
// Two-stage synchroniser for asynchronous comparator and pin levels
`timescale 1ns/1ps
`default_nettype none
module bsp_sync #(
  parameter int W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;

  initial begin
    if (W < 1) $error("bsp_sync: W must be at least 1");
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule
`default_nettype wire
